// ### inc/alarm_pkg.sv
// Purpose: shared constants for the alarm qualification block
// Assumes: 200 MHz mclk, 32-bit AXI4-Lite register port
// Notes:   temperatures are signed results in eighths of a degree
package alarm_pkg;

  // sources: 0..3 analog inputs, 4..6 remote diode one, remote diode two, local sensor
  localparam int NUM_AN   = 4;
  localparam int NUM_TEMP = 3;
  localparam int NUM_SRC  = 7;
  localparam int SRC_W    = 3;
  localparam int DATA_W   = 13;
  localparam int HYS_W    = 7;
  localparam int THYS_W   = 5;
  localparam int QHYS_W   = 14;
  localparam int CNT_W    = 9;
  localparam int STAT_W   = 11;
  localparam int ADDR_W   = 12;
  localparam int PWR_W    = 16;
  localparam int LOCAL_SRC = 6;

  // register byte offsets
  localparam logic [11:0] OFS_STATUS   = 12'h000;
  localparam logic [11:0] OFS_CTRL     = 12'h004;
  localparam logic [11:0] OFS_CFG1     = 12'h008;
  localparam logic [11:0] OFS_GLOBAL   = 12'h00c;
  localparam logic [11:0] OFS_SWRST    = 12'h010;
  localparam logic [11:0] OFS_PWR      = 12'h014;
  localparam logic [11:0] OFS_HI_BASE  = 12'h040;
  localparam logic [11:0] OFS_LO_BASE  = 12'h060;
  localparam logic [11:0] OFS_HYS_BASE = 12'h080;
  localparam logic [11:0] OFS_STRIDE   = 12'h004;

  // field positions
  localparam int CTRL_LATCH_DIS_BIT = 16;
  localparam int CFG_AN_CNT_LSB     = 0;
  localparam int CFG_TEMP_CNT_LSB   = 4;
  localparam int ST_UPPER_TEMP_LSB  = 4;
  localparam int ST_LOWER_TEMP_LSB  = 7;
  localparam int ST_OVERTEMP_BIT    = 10;

  // reset values
  localparam logic [2:0]        AN_CNT_DEF   = 3'h3;
  localparam logic [1:0]        TEMP_CNT_DEF = 2'h2;
  localparam logic [STAT_W-1:0] ENABLE_DEF   = 11'h000;
  localparam logic [PWR_W-1:0]  PWR_DEF      = 16'h0000;
  localparam logic [DATA_W-1:0] AN_HI_DEF    = 13'h0fff;
  localparam logic [DATA_W-1:0] AN_LO_DEF    = 13'h0000;
  localparam logic [DATA_W-1:0] TEMP_HI_DEF  = 13'h0fff;
  localparam logic [DATA_W-1:0] TEMP_LO_DEF  = 13'h1000;
  localparam logic [HYS_W-1:0]  HYS_DEF      = 7'h00;
  localparam logic [15:0]       SWRST_KEY    = 16'h6600;

  // temperature scaling and die overtemperature limit
  localparam int TEMP_FRAC_BITS = 3;
  localparam int OT_LIMIT_DEG   = 150;
  localparam int OT_HYS_DEG     = 8;
  localparam logic [DATA_W-1:0] OT_LIMIT_Q = 13'(OT_LIMIT_DEG << TEMP_FRAC_BITS);
  localparam logic [QHYS_W-1:0] OT_HYS_Q   = 14'(OT_HYS_DEG << TEMP_FRAC_BITS);

  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SRST_BUSY_NS  = 1000;
  localparam int SRST_CYCLES   = (SRST_BUSY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOST_WAIT_US  = 30;
  localparam int SRST_W        = 8;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [CNT_W-1:0] an_count(input logic [2:0] sel);
    // shift amount widened so that select 7 reaches 256 instead of wrapping to 0
    an_count = (sel == 3'h0) ? 9'h001 : 9'(9'h001 << ({1'b0, sel} + 4'h1));
  endfunction

  function automatic logic [CNT_W-1:0] temp_count(input logic [1:0] sel);
    temp_count = 9'(9'h001 << sel);
  endfunction

endpackage

// ### rtl/alarm_qualifier.sv
// Purpose: window check, consecutive-count filter and hysteresis for one source
// Assumes: sample_valid is a one-cycle strobe per finished conversion
// Notes:   upper and lower alarms share one out-of-range counter
`timescale 1ns/1ps
`default_nettype none
module alarm_qualifier
  import alarm_pkg::*;
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // conversion
  input  wire logic                     sample_valid,
  input  wire logic signed [DATA_W-1:0] sample,
  // settings
  input  wire logic signed [DATA_W-1:0] hi_thr,
  input  wire logic signed [DATA_W-1:0] lo_thr,
  input  wire logic [QHYS_W-1:0]        hys,
  input  wire logic [CNT_W-1:0]         n_target,
  // conditions
  output logic                          upper_active,
  output logic                          lower_active
);

  localparam int EW = DATA_W + 3;

  logic [CNT_W-1:0]   cnt_reg;
  logic [CNT_W-1:0]   cnt_next;
  logic [CNT_W:0]     cnt_inc;
  logic               upper_next;
  logic               lower_next;
  logic signed [EW-1:0] s_e;
  logic signed [EW-1:0] hi_e;
  logic signed [EW-1:0] lo_e;
  logic signed [EW-1:0] hys_e;
  logic               above;
  logic               below;

  assign s_e   = EW'(sample);
  assign hi_e  = EW'(hi_thr);
  assign lo_e  = EW'(lo_thr);
  assign hys_e = $signed({2'b00, hys});
  assign above = s_e > hi_e;
  assign below = s_e < lo_e;
  assign cnt_inc = {1'b0, cnt_reg} + 10'h001;

  always_comb
  begin
    cnt_next   = cnt_reg;
    upper_next = upper_active;
    lower_next = lower_active;
    if (sample_valid)
    begin
      if (above || below)
      begin
        if (cnt_reg < n_target)
          cnt_next = cnt_inc[CNT_W-1:0];
        if (cnt_inc >= {1'b0, n_target})
        begin
          upper_next = upper_active | above;
          lower_next = lower_active | below;
        end
      end
      else
        cnt_next = '0;
      if (upper_active && (s_e <= hi_e - hys_e))
        upper_next = 1'b0;
      if (lower_active && (s_e >= lo_e + hys_e))
        lower_next = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_reg      <= '0;
      upper_active <= 1'b0;
      lower_active <= 1'b0;
    end
    else
    begin
      cnt_reg      <= cnt_next;
      upper_active <= upper_next;
      lower_active <= lower_next;
    end
  end

endmodule
`default_nettype wire

// ### rtl/alarm_monitor_logic.sv
// Purpose: alarm status, alarm pin and reset handling of the monitor
// Assumes: conversion results arrive on mclk; host on AXI4-Lite
// Notes:   soft reset blocks the bus for SRST_CYCLES
// Contract
// - alarm pin is open drain, low active
// - enable bits gate pin, status still set
// - latched bit holds until resolved and read
// - status read clears latched bits; persisting alarms reassert
// - any reset clears status bits
// - unlatched bits follow their condition
// - clear only past hysteresis margin
// - per-source hysteresis, 127 LSB or 31 degrees
// - die overtemperature uses fixed 8 degrees
// - set only after N consecutive out-of-range
// - analog count select gives N, default 16
// - temperature count select gives N, default 4
// - reset pin holds all registers at default
// - soft reset register restores defaults
// - bus blocked while reset in progress
// - global flag ORs bits; pin ORs enabled bits
// - analog window from high and low thresholds
`timescale 1ns/1ps
`default_nettype none
module alarm_monitor_logic
  import alarm_pkg::*;
#(
  parameter bit FOUR_WIRE = 1'b0
)
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // register port
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [ADDR_W-1:0]        s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // conversion results
  input  wire logic                     res_valid,
  input  wire logic [SRC_W-1:0]         res_src,
  input  wire logic signed [DATA_W-1:0] res_data,
  // alarm pin and power control
  output logic                          alarm_o,
  output logic                          alarm_oe,
  output logic [PWR_W-1:0]              power_down_ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [ADDR_W-1:0]        awaddr_reg, awaddr_next, araddr_w;
  logic                     aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [31:0]              wdata_reg, wdata_next;
  logic [3:0]               wstrb_reg, wstrb_next;
  logic                     awready_next, wready_next, arready_next;
  logic                     bvalid_next, rvalid_next;
  logic [1:0]               bresp_next, rresp_next;
  logic [31:0]              rdata_next;
  logic                     do_write, rd_take, st_read;
  logic [SRST_W-1:0]        srst_reg, srst_next;
  logic                     busy_reg, cfg_clear, qual_rst_n;
  logic [STAT_W-1:0]        enable_reg, enable_next;
  logic                     latch_dis_reg, latch_dis_next;
  logic [2:0]               an_sel_reg, an_sel_next;
  logic [1:0]               temp_sel_reg, temp_sel_next;
  logic [PWR_W-1:0]         pwr_next;
  logic signed [DATA_W-1:0] hi_reg [NUM_SRC];
  logic signed [DATA_W-1:0] hi_next [NUM_SRC];
  logic signed [DATA_W-1:0] lo_reg [NUM_SRC];
  logic signed [DATA_W-1:0] lo_next [NUM_SRC];
  logic [HYS_W-1:0]         hys_reg [NUM_SRC];
  logic [HYS_W-1:0]         hys_next [NUM_SRC];
  logic [STAT_W-1:0]        status_reg, status_next, cond, upd;
  logic                     global_reg, global_next, alarm_oe_next;
  logic [NUM_SRC-1:0]       up_act, lo_act, src_hit;
  logic                     ot_act;
  logic [NUM_SRC-1:0]       hit_reg;
  logic [31:0]              wr_val;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
  endfunction

  function automatic logic [ADDR_W-1:0] slot(input logic [ADDR_W-1:0] base, input int i);
    slot = base + ADDR_W'(i * 4);
  endfunction

  assign busy_reg   = srst_reg != '0;
  assign cfg_clear  = !rst_n || busy_reg;
  assign qual_rst_n = !cfg_clear;
  assign araddr_w   = s_axi_araddr;

  ////////////////////////////////////////////////////////////////////////////
  // qualification per source
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_src
      logic [QHYS_W-1:0] hys_q;
      logic [CNT_W-1:0]  n_q;
      if (g < NUM_AN)
      begin : g_an
        assign hys_q = QHYS_W'(hys_reg[g]);
        assign n_q   = an_count(an_sel_reg);
      end
      else
      begin : g_tmp
        assign hys_q = QHYS_W'({hys_reg[g][THYS_W-1:0], 3'h0});
        assign n_q   = temp_count(temp_sel_reg);
      end
      assign src_hit[g] = res_valid && (res_src == SRC_W'(g));
      alarm_qualifier u_qual (
        .mclk         (mclk),
        .rst_n        (qual_rst_n),
        .sample_valid (src_hit[g]),
        .sample       (res_data),
        .hi_thr       (hi_reg[g]),
        .lo_thr       (lo_reg[g]),
        .hys          (hys_q),
        .n_target     (n_q),
        .upper_active (up_act[g]),
        .lower_active (lo_act[g])
      );
    end
  endgenerate

  alarm_qualifier u_overtemp (
    .mclk         (mclk),
    .rst_n        (qual_rst_n),
    .sample_valid (src_hit[LOCAL_SRC]),
    .sample       (res_data),
    .hi_thr       (OT_LIMIT_Q),
    .lo_thr       (TEMP_LO_DEF),
    .hys          (OT_HYS_Q),
    .n_target     (CNT_W'(1)),
    .upper_active (ot_act),
    .lower_active ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // status, global flag and pin
  always_comb
  begin
    cond = '0;
    upd  = '0;
    for (int i = 0; i < NUM_AN; i++)
    begin
      cond[i] = up_act[i] | lo_act[i];
      upd[i]  = hit_reg[i];
    end
    for (int t = 0; t < NUM_TEMP; t++)
    begin
      cond[ST_UPPER_TEMP_LSB + t] = up_act[NUM_AN + t];
      cond[ST_LOWER_TEMP_LSB + t] = lo_act[NUM_AN + t];
      upd[ST_UPPER_TEMP_LSB + t]  = hit_reg[NUM_AN + t];
      upd[ST_LOWER_TEMP_LSB + t]  = hit_reg[NUM_AN + t];
    end
    cond[ST_OVERTEMP_BIT] = ot_act;
    upd[ST_OVERTEMP_BIT]  = hit_reg[LOCAL_SRC];
    if (latch_dis_reg)
      status_next = cond;
    else
      status_next = (status_reg & ~{STAT_W{st_read}}) | (cond & upd);
    global_next   = |status_reg;
    alarm_oe_next = |(status_reg & enable_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes and soft reset
  always_comb
  begin
    enable_next    = enable_reg;
    latch_dis_next = latch_dis_reg;
    an_sel_next    = an_sel_reg;
    temp_sel_next  = temp_sel_reg;
    pwr_next       = power_down_ctrl;
    hi_next        = hi_reg;
    lo_next        = lo_reg;
    hys_next       = hys_reg;
    srst_next      = busy_reg ? srst_reg - SRST_W'(1) : srst_reg;
    wr_val         = 32'h0000_0000;
    if (do_write)
    begin
      if (awaddr_reg == OFS_CTRL)
      begin
        wr_val         = merge({15'h0, latch_dis_reg, 5'h0, enable_reg}, wdata_reg, wstrb_reg);
        enable_next    = wr_val[STAT_W-1:0];
        latch_dis_next = wr_val[CTRL_LATCH_DIS_BIT];
      end
      if (awaddr_reg == OFS_CFG1)
      begin
        wr_val        = merge({26'h0, temp_sel_reg, 1'b0, an_sel_reg}, wdata_reg, wstrb_reg);
        an_sel_next   = wr_val[CFG_AN_CNT_LSB +: 3];
        temp_sel_next = wr_val[CFG_TEMP_CNT_LSB +: 2];
      end
      if (awaddr_reg == OFS_PWR)
      begin
        wr_val   = merge({16'h0, power_down_ctrl}, wdata_reg, wstrb_reg);
        pwr_next = wr_val[PWR_W-1:0];
      end
      if (awaddr_reg == OFS_SWRST && (!FOUR_WIRE || wdata_reg[15:0] == SWRST_KEY))
        srst_next = SRST_W'(SRST_CYCLES);
      for (int i = 0; i < NUM_SRC; i++)
      begin
        if (awaddr_reg == slot(OFS_HI_BASE, i))
          hi_next[i] = DATA_W'(merge(32'(hi_reg[i]), wdata_reg, wstrb_reg));
        if (awaddr_reg == slot(OFS_LO_BASE, i))
          lo_next[i] = DATA_W'(merge(32'(lo_reg[i]), wdata_reg, wstrb_reg));
        if (awaddr_reg == slot(OFS_HYS_BASE, i))
          hys_next[i] = HYS_W'(merge(32'(hys_reg[i]), wdata_reg, wstrb_reg));
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      srst_reg <= '0;
    else
      srst_reg <= srst_next;
    if (cfg_clear)
    begin
      enable_reg      <= ENABLE_DEF;
      latch_dis_reg   <= 1'b0;
      an_sel_reg      <= AN_CNT_DEF;
      temp_sel_reg    <= TEMP_CNT_DEF;
      power_down_ctrl <= PWR_DEF;
      status_reg      <= '0;
      global_reg      <= 1'b0;
      alarm_oe        <= 1'b0;
      hit_reg         <= '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
        hi_reg[i]  <= (i < NUM_AN) ? AN_HI_DEF : TEMP_HI_DEF;
        lo_reg[i]  <= (i < NUM_AN) ? AN_LO_DEF : TEMP_LO_DEF;
        hys_reg[i] <= HYS_DEF;
      end
    end
    else
    begin
      enable_reg      <= enable_next;
      latch_dis_reg   <= latch_dis_next;
      an_sel_reg      <= an_sel_next;
      temp_sel_reg    <= temp_sel_next;
      power_down_ctrl <= pwr_next;
      status_reg      <= status_next;
      global_reg      <= global_next;
      alarm_oe        <= alarm_oe_next;
      // conversion marker delayed to meet the qualifier's updated condition
      hit_reg         <= src_hit;
      hi_reg          <= hi_next;
      lo_reg          <= lo_next;
      hys_reg         <= hys_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFS_STATUS) || (a == OFS_CTRL) || (a == OFS_CFG1) || (a == OFS_GLOBAL)
          || (a == OFS_SWRST) || (a == OFS_PWR);
    for (int i = 0; i < NUM_SRC; i++)
      mapped = mapped || a == slot(OFS_HI_BASE, i) || a == slot(OFS_LO_BASE, i)
                      || a == slot(OFS_HYS_BASE, i);
  endfunction

  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign rd_take  = s_axi_arvalid && s_axi_arready;
  assign st_read  = rd_take && araddr_w == OFS_STATUS;

  always_comb
  begin
    aw_held_next = aw_held_reg;
    awaddr_next  = awaddr_reg;
    w_held_next  = w_held_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = s_axi_bvalid;
    bresp_next   = s_axi_bresp;
    rvalid_next  = s_axi_rvalid;
    rresp_next   = s_axi_rresp;
    rdata_next   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_next = 1'b1;
      awaddr_next  = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_next = 1'b0;
    if (do_write)
    begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready)
      rvalid_next = 1'b0;
    if (rd_take)
    begin
      rvalid_next = 1'b1;
      rresp_next  = mapped({araddr_w[ADDR_W-1:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      rdata_next  = 32'h0000_0000;
      case ({araddr_w[ADDR_W-1:2], 2'b00})
        OFS_STATUS: rdata_next = 32'(status_reg);
        OFS_CTRL:   rdata_next = {15'h0, latch_dis_reg, 5'h0, enable_reg};
        OFS_CFG1:   rdata_next = {26'h0, temp_sel_reg, 1'b0, an_sel_reg};
        OFS_GLOBAL: rdata_next = {31'h0, global_reg};
        OFS_PWR:    rdata_next = {16'h0, power_down_ctrl};
        default:
        begin
          for (int i = 0; i < NUM_SRC; i++)
          begin
            if ({araddr_w[ADDR_W-1:2], 2'b00} == slot(OFS_HI_BASE, i))
              rdata_next = 32'(hi_reg[i]);
            if ({araddr_w[ADDR_W-1:2], 2'b00} == slot(OFS_LO_BASE, i))
              rdata_next = 32'(lo_reg[i]);
            if ({araddr_w[ADDR_W-1:2], 2'b00} == slot(OFS_HYS_BASE, i))
              rdata_next = 32'(hys_reg[i]);
          end
        end
      endcase
    end
    // blocked while a reset runs
    awready_next = !aw_held_next && !bvalid_next && srst_next == '0;
    wready_next  = !w_held_next && !bvalid_next && srst_next == '0;
    arready_next = !rvalid_next && srst_next == '0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      aw_held_reg   <= 1'b0;
      awaddr_reg    <= '0;
      w_held_reg    <= 1'b0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= '0;
      alarm_o       <= 1'b0;
    end
    else
    begin
      aw_held_reg   <= aw_held_next;
      awaddr_reg    <= awaddr_next;
      w_held_reg    <= w_held_next;
      wdata_reg     <= wdata_next;
      wstrb_reg     <= wstrb_next;
      s_axi_awready <= awready_next;
      s_axi_wready  <= wready_next;
      s_axi_arready <= arready_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_bresp   <= bresp_next;
      s_axi_rvalid  <= rvalid_next;
      s_axi_rresp   <= rresp_next;
      s_axi_rdata   <= rdata_next;
      alarm_o       <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### dv/alarm_monitor_sva.sv
// Purpose: port checks of the alarm monitor
// Assumes: default FOUR_WIRE, any soft reset data counts
// Notes:   one clock domain
`timescale 1ns/1ps
`default_nettype none
module alarm_monitor_sva
  import alarm_pkg::*;
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // register port
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // pin and power
  input wire logic              alarm_o,
  input wire logic              alarm_oe,
  input wire logic [PWR_W-1:0]  power_down_ctrl
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_swrst;
    s_wr ##0 s_axi_awaddr == OFS_SWRST;
  endsequence
  property p_od; alarm_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin value high");
  property p_rst; !$past(rst_n) |-> !alarm_oe && power_down_ctrl == '0; endproperty
  a_rst: assert property (p_rst) else $error("output set after reset");
  property p_blk; s_swrst |=> ##1 (!s_axi_awready && !s_axi_arready)[*8]; endproperty
  a_blk: assert property (p_blk) else $error("bus open in soft reset");
  property p_wr; s_wr |=> ##1 s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("no write answer");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_bst; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bst: assert property (p_bst) else $error("write answer dropped");
  property p_rst_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("read answer dropped");
  property p_unm; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h7fc
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read answered");
endmodule
bind alarm_monitor_logic alarm_monitor_sva u_sva (.mclk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .alarm_o, .alarm_oe, .power_down_ctrl);
`default_nettype wire

// ### dv/alarm_host.sv
// Purpose: host side of the alarm pin
// Assumes: wire pulled up outside the device
// Notes:   pin_n is what the host interrupt input sees
`timescale 1ns/1ps
`default_nettype none
module alarm_host
(
  // pin
  input  wire logic alarm_o,
  input  wire logic alarm_oe,
  // host view
  output logic      pin_n
);
  assign pin_n = alarm_oe ? alarm_o : 1'b1;
endmodule
`default_nettype wire

// ### dv/alarm_monitor_logic_bench.sv
// Purpose: self-checking bench of the alarm monitor
// Assumes: AXI4-Lite master tasks, results driven directly
// Notes:   host waits after soft reset before talking again
`timescale 1ns/1ps
`default_nettype none
module alarm_monitor_logic_bench
  import alarm_pkg::*;
;
  logic              mclk = 1'b0, rst_n = 1'b0, vld = 1'b0;
  logic              awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic              awr, wrd, bv, arr, rv, ao, oe, pin_n;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [31:0]       wd = '0, rdat;
  logic [1:0]        bresp, rresp;
  logic [SRC_W-1:0]  src = '0;
  logic [DATA_W-1:0] dat = '0;
  logic [PWR_W-1:0]  pwr;
  int                fails = 0, comparisons = 0;
  always #2.5 mclk = ~mclk;
  alarm_monitor_logic u_dut (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .res_valid(vld), .res_src(src), .res_data(dat),
    .alarm_o(ao), .alarm_oe(oe), .power_down_ctrl(pwr));
  alarm_host u_host (.alarm_o(ao), .alarm_oe(oe), .pin_n(pin_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // readies are looked at on the falling edge, taken at the next rising one
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(ad && dd))
    begin
      @(negedge mclk);
      ad = ad | awr;
      dd = dd | wrd;
      @(posedge mclk);
      awv <= awv & !ad;
      wv <= wv & !dd;
    end
    do @(negedge mclk); while (!bv);
    chk(32'(bresp), 32'(er));
    @(posedge mclk);
    br <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(negedge mclk); while (!arr);
    @(posedge mclk);
    arv <= 1'b0;
    do @(negedge mclk); while (!rv);
    chk(rdat, e);
    chk(32'(rresp), 32'(er));
    @(posedge mclk);
    rr <= 1'b0;
  endtask
  task automatic cv(input logic [2:0] s, input int d);
    @(posedge mclk);
    vld <= 1'b1;
    src <= s;
    dat <= 13'(d);
    @(posedge mclk);
    vld <= 1'b0;
    // status settles one edge, global flag and pin two edges after the result is taken
    repeat (2) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge mclk);
    fails++;
    final_report();
  end
  initial
  begin
    logic [2:0] s;
    int n;
    logic [31:0] b;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_CFG1, 32'h23);
    rd(OFS_STATUS, 32'h0);
    rd(12'h7fc, 32'h0, RESP_SLVERR);
    wr(12'h7fc, 32'h1, RESP_SLVERR);
    wr(OFS_HI_BASE, 32'd100);
    wr(OFS_HYS_BASE, 32'd10);
    wr(OFS_HI_BASE + 12'h010, 32'd800);
    for (int k = 0; k < 12; k++)
    begin
      s = k < 8 ? 3'h0 : 3'h4;
      n = k < 8 ? (k == 0 ? 1 : 2 << k) : 1 << (k - 8);
      b = k < 8 ? 32'h1 : 32'h10;
      wr(OFS_CFG1, k < 8 ? 32'(k) : 32'(k - 8) << 4);
      repeat (n - 1) cv(s, 900);
      cv(s, 0);
      repeat (n - 1) cv(s, 900);
      rd(OFS_STATUS, 32'h0);
      cv(s, 900);
      cv(s, 0);
      rd(OFS_STATUS, b);
      rd(OFS_STATUS, 32'h0);
    end
    wr(OFS_CFG1, 32'h0);
    cv(0, 900);
    rd(OFS_GLOBAL, 32'h1);
    chk(32'(pin_n), 32'h1);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_CTRL, 32'h1);
    cv(0, 95);
    rd(OFS_GLOBAL, 32'h1);
    chk(32'(pin_n), 32'h0);
    rd(OFS_STATUS, 32'h1);
    cv(0, 90);
    rd(OFS_STATUS, 32'h0);
    chk(32'(pin_n), 32'h1);
    cv(6, 1201);
    rd(OFS_STATUS, 32'h400);
    cv(6, 1137);
    rd(OFS_STATUS, 32'h400);
    cv(6, 1136);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_CTRL, 32'h10001);
    cv(0, 900);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h1);
    cv(0, 0);
    rd(OFS_STATUS, 32'h0);
    cv(0, 900);
    wr(OFS_PWR, 32'h1234);
    chk(32'(pwr), 32'h1234);
    wr(OFS_SWRST, 32'h5a5a);
    repeat (6000) @(posedge mclk);
    rd(OFS_PWR, 32'h0);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_PWR, 32'h00ff);
    rst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(32'(pwr), 32'h0);
    rst_n <= 1'b1;
    rd(OFS_PWR, 32'h0);
    rd(OFS_CFG1, 32'h23);
    final_report();
  end
endmodule
`default_nettype wire
